// *** src/rcp_regs.v ***
// Configuration page two register bank with checksum result, pulse width and gain
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "rcp_map.vh"
module rcp_regs #(
    parameter ADDR_BITS = 8,
    parameter SUM_BITS  = 16
) (
    // Clock and reset
    input  wire                 mclk,
    input  wire                 rst,
    // Register port
    input  wire [ADDR_BITS-1:0] reg_addr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [7:0]           reg_rdata,
    // Checksum engine
    input  wire [SUM_BITS-1:0]  sum_result,
    input  wire                 sum_load,
    input  wire                 checksum_done_flag,
    output reg                  sum_valid_q,
    // Modulator
    input  wire                 mod_start,
    output wire                 mod_pulse,
    output reg  [7:0]           pulse_width_value,
    // Receiver
    output reg  [2:0]           receiver_gain_select,
    output reg  [5:0]           gain_db
);

    // Local address decode
    localparam [ADDR_BITS-1:0] A_RSVD_A = `RCP_OFS_RSVD_A;
    localparam [ADDR_BITS-1:0] A_HIGH   = `RCP_OFS_SUM_HIGH;
    localparam [ADDR_BITS-1:0] A_LOW    = `RCP_OFS_SUM_LOW;
    localparam [ADDR_BITS-1:0] A_RSVD_B = `RCP_OFS_RSVD_B;
    localparam [ADDR_BITS-1:0] A_WIDTH  = `RCP_OFS_PULSE_WIDTH;
    localparam [ADDR_BITS-1:0] A_RSVD_C = `RCP_OFS_RSVD_C;
    localparam [ADDR_BITS-1:0] A_GAIN   = `RCP_OFS_GAIN_CFG;
    localparam [ADDR_BITS-1:0] A_STATUS = `RCP_OFS_STATUS;

    // Reserved bits of the gain register keep returning their reset pattern
    localparam [7:0]           GAIN_RST_BYTE = `RCP_RST_GAIN_CFG;

    // Stored state and combinational decode results
    reg [7:0]  sum_high_q;
    reg [7:0]  sum_low_q;
    reg [7:0]  width_q;
    reg [2:0]  gain_q;
    reg [7:0]  rdata_d;
    reg [5:0]  db_d;

    // Write strobes for the writable places only
    wire wr_width = reg_wr && (reg_addr == A_WIDTH);
    wire wr_gain  = reg_wr && (reg_addr == A_GAIN);

    // Checksum bytes are loaded only by the engine, never by software
    always @(posedge mclk) begin
        if (rst) begin
            sum_high_q <= `RCP_RST_SUM_BYTE;
            sum_low_q  <= `RCP_RST_SUM_BYTE;
        end else if (sum_load) begin
            sum_high_q <= sum_result[SUM_BITS-1:SUM_BITS-8];
            sum_low_q  <= sum_result[7:0];
        end
    end

    // Validity of the checksum follows the engine's done flag
    always @(posedge mclk) begin
        if (rst) begin
            sum_valid_q <= 1'b0;
        end else begin
            sum_valid_q <= checksum_done_flag;
        end
    end

    // Pulse width register
    always @(posedge mclk) begin
        if (rst) begin
            width_q <= `RCP_RST_PULSE_WIDTH;
        end else if (wr_width) begin
            width_q <= reg_wdata;
        end
    end

    // Gain field; reserved bits of the write are dropped
    always @(posedge mclk) begin
        if (rst) begin
            gain_q <= `RCP_GAIN_RST;
        end else if (wr_gain) begin
            gain_q <= reg_wdata[`RCP_GAIN_HI:`RCP_GAIN_LO];
        end
    end

    // Decode of the gain code into dB
    always @* begin
        case (gain_q)
            3'h0:    db_d = `RCP_DB_18;
            3'h1:    db_d = `RCP_DB_23;
            3'h2:    db_d = `RCP_DB_18;
            3'h3:    db_d = `RCP_DB_23;
            3'h4:    db_d = `RCP_DB_33;
            3'h5:    db_d = `RCP_DB_38;
            3'h6:    db_d = `RCP_DB_43;
            default: db_d = `RCP_DB_48;
        endcase
    end

    // Registered copies of the settings for the analogue and modulator sides
    always @(posedge mclk) begin
        if (rst) begin
            pulse_width_value    <= `RCP_RST_PULSE_WIDTH;
            receiver_gain_select <= `RCP_GAIN_RST;
            gain_db              <= `RCP_DB_33;
        end else begin
            pulse_width_value    <= width_q;
            receiver_gain_select <= gain_q;
            gain_db              <= db_d;
        end
    end

    // Read mux; reserved places return constants whatever was written
    always @* begin
        case (reg_addr)
            A_RSVD_A: rdata_d = `RCP_RST_RSVD_A;
            A_HIGH:   rdata_d = sum_high_q;
            A_LOW:    rdata_d = sum_low_q;
            A_RSVD_B: rdata_d = `RCP_RST_RSVD_B;
            A_WIDTH:  rdata_d = width_q;
            A_RSVD_C: rdata_d = `RCP_RST_RSVD_C;
            A_GAIN:   rdata_d = {GAIN_RST_BYTE[7], gain_q, GAIN_RST_BYTE[3:0]};
            A_STATUS: rdata_d = {6'h00, mod_pulse, sum_valid_q};
            default:  rdata_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the read strobe
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Modulation pulse generator; width limit is left to software
    rcp_pulse #(
        .WIDTH_BITS (8)
    ) u_pulse (
        .mclk    (mclk),
        .rst     (rst),
        .start   (mod_start),
        .width   (width_q),
        .pulse_q (mod_pulse)
    );

endmodule // rcp_regs

// *** src/rcp_map.vh ***
// Register map, field positions and reset values of configuration page two
`ifndef RCP_MAP_VH
`define RCP_MAP_VH

// Register offsets
`define RCP_OFS_RSVD_A      8'h20
`define RCP_OFS_SUM_HIGH    8'h21
`define RCP_OFS_SUM_LOW     8'h22
`define RCP_OFS_RSVD_B      8'h23
`define RCP_OFS_PULSE_WIDTH 8'h24
`define RCP_OFS_RSVD_C      8'h25
`define RCP_OFS_GAIN_CFG    8'h26
`define RCP_OFS_STATUS      8'h2f

// Reset values
`define RCP_RST_RSVD_A      8'h00
`define RCP_RST_SUM_BYTE    8'hff
`define RCP_RST_RSVD_B      8'h88
`define RCP_RST_PULSE_WIDTH 8'h26
`define RCP_RST_RSVD_C      8'h87
`define RCP_RST_GAIN_CFG    8'h48

// Gain config field layout
`define RCP_GAIN_HI         6
`define RCP_GAIN_LO         4
`define RCP_GAIN_RST        3'h4

// Status register bits
`define RCP_ST_DONE_BIT     0
`define RCP_ST_BUSY_BIT     1

// Gain values in dB
`define RCP_DB_18           6'h12
`define RCP_DB_23           6'h17
`define RCP_DB_33           6'h21
`define RCP_DB_38           6'h26
`define RCP_DB_43           6'h2b
`define RCP_DB_48           6'h30

`endif

// *** src/rcp_pulse.v ***
// Modulation pulse generator: one start gives a pulse of width plus one cycles
`timescale 1ns/10ps
module rcp_pulse #(
    parameter WIDTH_BITS = 8
) (
    // Clock and reset
    input  wire                  mclk,
    input  wire                  rst,
    // Control
    input  wire                  start,
    input  wire [WIDTH_BITS-1:0] width,
    // Pulse
    output reg                   pulse_q
);

    reg [WIDTH_BITS-1:0] cnt_q;

    // Start is ignored while a pulse runs; width is sampled at the start
    always @(posedge mclk) begin
        if (rst) begin
            pulse_q <= 1'b0;
            cnt_q   <= {WIDTH_BITS{1'b0}};
        end else if (pulse_q) begin
            if (cnt_q == {WIDTH_BITS{1'b0}}) begin
                pulse_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end else if (start) begin
            pulse_q <= 1'b1;
            cnt_q   <= width;
        end
    end

endmodule // rcp_pulse

// *** tb/rcp_regs_props.sv ***
// Assertion checker for the page two register bank
`timescale 1ns/10ps
module rcp_regs_props #(parameter ADDR_BITS = 8, parameter SUM_BITS = 16) (
    // Clock, reset and register port
    input wire mclk, rst, reg_wr, reg_rd,
    input wire [ADDR_BITS-1:0] reg_addr,
    input wire [7:0] reg_wdata, reg_rdata, pulse_width_value,
    // Checksum, modulator and receiver
    input wire [SUM_BITS-1:0] sum_result,
    input wire sum_load, checksum_done_flag, sum_valid_q, mod_start, mod_pulse,
    input wire [2:0] receiver_gain_select,
    input wire [5:0] gain_db
);
    reg [8:0] cnt_q;
    reg [7:0] w_q;
    reg       start_seen_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Counts pulse cycles and keeps the width seen at start
    always @(posedge mclk) begin
        cnt_q        <= (mod_pulse && !rst) ? cnt_q + 9'h1 : 9'h0;
        start_seen_q <= mod_start && !mod_pulse && !rst;
        // The width view lags the register by one cycle, so take it one cycle after start
        if (start_seen_q) w_q <= pulse_width_value;
    end
    property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_rsvd; reg_rd && reg_addr == 8'h23 |=> reg_rdata == 8'h88; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved value");
    property p_hi; sum_load ##1 !sum_load ##1 (reg_rd && reg_addr == 8'h21 && !sum_load)
        |=> reg_rdata == $past(sum_result[15:8], 3); endproperty
    a_hi: assert property (p_hi) else $error("checksum high byte");
    property p_valid; !$past(rst) |-> sum_valid_q == $past(checksum_done_flag); endproperty
    a_valid: assert property (p_valid) else $error("done flag copy");
    property p_start; mod_start && !mod_pulse |=> mod_pulse; endproperty
    a_start: assert property (p_start) else $error("pulse start");
    property p_len; $fell(mod_pulse) |-> cnt_q == {1'b0, w_q} + 9'h1; endproperty
    a_len: assert property (p_len) else $error("pulse length");
    property p_gain; reg_wr && reg_addr == 8'h26
        |=> ##1 receiver_gain_select == $past(reg_wdata[6:4], 2); endproperty
    a_gain: assert property (p_gain) else $error("gain select");
    property p_gainrd; reg_rd && reg_addr == 8'h26
        |=> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h8; endproperty
    a_gainrd: assert property (p_gainrd) else $error("gain reserved bits");
    property p_db; gain_db == (receiver_gain_select[2] ?
        6'h21 + 6'h5 * {4'h0, receiver_gain_select[1:0]} :
        (receiver_gain_select[0] ? 6'h17 : 6'h12)); endproperty
    a_db: assert property (p_db) else $error("gain dB");
    c_pulse: cover property ($fell(mod_pulse));
    c_load: cover property (sum_load);
    c_gain: cover property (reg_wr && reg_addr == 8'h26);
endmodule // rcp_regs_props
bind rcp_regs rcp_regs_props #(.ADDR_BITS(ADDR_BITS), .SUM_BITS(SUM_BITS)) u_rcp_regs_props (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pulse_width_value(pulse_width_value),
    .sum_result(sum_result), .sum_load(sum_load), .checksum_done_flag(checksum_done_flag),
    .sum_valid_q(sum_valid_q), .mod_start(mod_start), .mod_pulse(mod_pulse),
    .receiver_gain_select(receiver_gain_select), .gain_db(gain_db));

// *** tb/rcp_regs_bench.sv ***
// Self-checking bench for the page two register bank
`timescale 1ns/10ps
module rcp_regs_bench;
    reg mclk = 0, rst = 1, wr_s = 0, rd_s = 0, load = 0, done = 0, start = 0;
    reg [7:0] addr = 0, wdata = 0;
    reg [15:0] sum = 0;
    wire [7:0] rdata, pw;
    wire [2:0] gsel;
    wire [5:0] db;
    wire valid, pulse;
    integer err_total = 0, checks_done = 0, cyc = 0, i, n;
    // Reset values of 20h to 26h and dB per gain code
    reg [55:0] dflt = 56'h48872688ffff00;
    reg [63:0] gdb = 64'h302b262117121712;
    always #4 mclk = ~mclk;
    // Cycle ceiling against hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            results;
        end
    end
    rcp_regs u_rcp_regs (.mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .sum_result(sum), .sum_load(load),
        .checksum_done_flag(done), .sum_valid_q(valid), .mod_start(start), .mod_pulse(pulse),
        .pulse_width_value(pw), .receiver_gain_select(gsel), .gain_db(db));
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk) {addr, wdata, wr_s} <= {a, d, 1'b1};
            @(posedge mclk) wr_s <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(posedge mclk) {addr, rd_s} <= {a, 1'b1};
            @(posedge mclk) rd_s <= 1'b0;
            #1 chk(rdata, exp);
        end
    endtask
    task results;
        begin
            if (err_total == 0 && checks_done > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 7; i = i + 1) rd(8'h20 + i[7:0], dflt[8*i +: 8]);
        rd(8'h30, 8'h00);
        for (i = 0; i < 4; i = i + 1) wr(8'h20 + i[7:0] + (i == 3 ? 8'h2 : 8'h0), 8'h5a);
        for (i = 0; i < 6; i = i + 1) if (i != 4) rd(8'h20 + i[7:0], dflt[8*i +: 8]);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge mclk) {sum, load, done} <= {i ? 16'h5678 : 16'h1234, 2'b11};
            @(posedge mclk) load <= 1'b0;
            rd(8'h21 + i[7:0], i ? 8'h78 : 8'h12);
        end
        rd(8'h21, 8'h56);
        chk({7'h0, valid}, 8'h01);
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h26, {1'b1, i[2:0], 4'h7});
            rd(8'h26, {1'b0, i[2:0], 4'h8});
            chk({5'h0, gsel}, i[7:0]);
            chk({2'h0, db}, gdb[8*i +: 8]);
        end
        wr(8'h24, 8'h10);
        rd(8'h24, 8'h10);
        chk(pw, 8'h10);
        rd(8'h2f, 8'h01);
        @(posedge mclk) start <= 1'b1;
        @(posedge mclk) start <= 1'b0;
        n = 0;
        #1 while (pulse === 1'b1 && n < 300) begin
            n = n + 1;
            @(posedge mclk) #1;
        end
        chk(n[7:0], 8'h11);
        // Second pulse with the done flag dropped: status shows busy pulse, invalid checksum
        @(posedge mclk) {start, done} <= 2'b10;
        @(posedge mclk) start <= 1'b0;
        rd(8'h2f, 8'h02);
        results;
    end
endmodule // rcp_regs_bench
